// ===== src/phy_diag_pkg.sv
// Constants, field layout and types of the per-port cable test,
// link state, symbol error count and link event register group.
// Assumes 16-bit registers addressed by the low 12 address bits.
package phy_diag_pkg;

  // Register offsets within one port's window
  localparam logic [11:0] OFS_DIAG      = 12'h124;
  localparam logic [11:0] OFS_LINK      = 12'h126;
  localparam logic [11:0] OFS_SYMERR    = 12'h12A;
  localparam logic [11:0] OFS_IRQ       = 12'h136;
  localparam logic [11:0] OFS_PHYCTL    = 12'h13E;

  // Field positions
  localparam int DIAG_START_BIT = 15;
  localparam int DIAG_RSV_HI    = 14;
  localparam int DIAG_PAIR_LSB  = 12;
  localparam int DIAG_RSV_LSB   = 10;
  localparam int DIAG_STAT_LSB  = 8;
  localparam int DIAG_DIST_LSB  = 0;
  localparam int LINK_GIG_BIT   = 1;
  localparam int LINK_FAST_BIT  = 0;
  localparam int IRQ_EN_LSB     = 8;
  localparam int JABBER_EN_BIT  = 9;
  localparam int NUM_EVT        = 8;

  // Event bit order, shared by enable and status bytes
  localparam int EVT_JABBER     = 7;
  localparam int EVT_RX_ERR     = 6;
  localparam int EVT_PAGE_RX    = 5;
  localparam int EVT_PAR_DET    = 4;
  localparam int EVT_PART_ACK   = 3;
  localparam int EVT_LINK_DOWN  = 2;
  localparam int EVT_REM_FAULT  = 1;
  localparam int EVT_LINK_UP    = 0;

  // Reset values
  localparam logic [1:0]  DIAG_RSV_LO_RST = 2'h0;
  localparam logic        DIAG_RSV_HI_RST = 1'h0;
  localparam logic [7:0]  IRQ_EN_RST      = 8'h00;
  localparam logic [7:0]  DIST_RST        = 8'h00;
  localparam logic        JABBER_EN_RST   = 1'h1;
  localparam logic [15:0] CNT_RST         = 16'h0000;
  localparam logic [15:0] CNT_MAX         = 16'hFFFF;
  localparam logic [15:0] RD_ZERO         = 16'h0000;

  typedef enum logic [1:0] {PAIR_A, PAIR_B, PAIR_C, PAIR_D} diag_pair_t;
  typedef enum logic [1:0] {DIAG_NORMAL, DIAG_OPEN, DIAG_SHORT, DIAG_FAILED} diag_outcome_t;
  typedef enum logic {DIAG_IDLE, DIAG_RUN} diag_state_t;

endpackage

// ===== src/phy_diag_ifs.sv
// Interfaces joining the register front end to the test sequencer
// and to the sticky event flag bank. Single clock domain.
`timescale 1ns/100ps
interface diag_if;
  logic                       startReq;
  logic                       stopReq;
  phy_diag_pkg::diag_pair_t   pairSel;
  logic                       busy;
  phy_diag_pkg::diag_outcome_t outcome;
  logic [7:0]                 distance;
  modport ctrl (output startReq, output stopReq, output pairSel,
                input busy, input outcome, input distance);
  modport seq  (input startReq, input stopReq, input pairSel,
                output busy, output outcome, output distance);
endinterface

interface flag_if #(parameter int W = 8);
  logic [W-1:0] setVec;
  logic         clrAll;
  logic [W-1:0] flags;
  modport owner (output setVec, output clrAll, input flags);
  modport bank  (input setVec, input clrAll, output flags);
endinterface

// ===== src/event_flag_bank.sv
// Sticky event flags: set by hardware pulses, cleared all at once.
// Assumes set and clear pulses are synchronous to core_clk.
`timescale 1ns/100ps
module event_flag_bank #(
  parameter int W = 8
) (
  input  wire logic core_clk,
  input  wire logic srst,
  flag_if.bank      fb
);
  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  // Set beats clear so an event landing on the clearing read survives
  always_comb begin
    flags_nxt = (flags_r & ~{W{fb.clrAll}}) | fb.setVec;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign fb.flags = flags_r;
endmodule

// ===== src/cable_diag_seq.sv
// Cable test sequencer: starts, aborts and collects one pair test.
// Assumes the analog tester holds its outcome valid with testDone.
`timescale 1ns/100ps
module cable_diag_seq (
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  diag_if.seq                              dif,
  output logic                             testRun,
  output phy_diag_pkg::diag_pair_t         testPair,
  input  wire logic                        testDone,
  input  wire phy_diag_pkg::diag_outcome_t testOutcome,
  input  wire logic [7:0]                  testDistance
);
  phy_diag_pkg::diag_state_t   state_r, state_nxt;
  phy_diag_pkg::diag_pair_t    pair_r, pair_nxt;
  phy_diag_pkg::diag_outcome_t outcome_r, outcome_nxt;
  logic [7:0]                  dist_r, dist_nxt;

  always_comb begin
    state_nxt   = state_r;
    pair_nxt    = pair_r;
    outcome_nxt = outcome_r;
    dist_nxt    = dist_r;
    case (state_r)
      phy_diag_pkg::DIAG_IDLE: begin
        if (dif.startReq) begin
          state_nxt = phy_diag_pkg::DIAG_RUN;
          pair_nxt  = dif.pairSel;
        end
      end
      phy_diag_pkg::DIAG_RUN: begin
        // Abort keeps the previous result; it wins over a same-cycle finish
        if (dif.stopReq) begin
          state_nxt = phy_diag_pkg::DIAG_IDLE;
        end else if (testDone) begin
          state_nxt   = phy_diag_pkg::DIAG_IDLE;
          outcome_nxt = testOutcome;
          dist_nxt    = testDistance;
        end
      end
      default: state_nxt = phy_diag_pkg::DIAG_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r   <= phy_diag_pkg::DIAG_IDLE;
      pair_r    <= phy_diag_pkg::PAIR_A;
      outcome_r <= phy_diag_pkg::DIAG_NORMAL;
      dist_r    <= phy_diag_pkg::DIST_RST;
    end else begin
      state_r   <= state_nxt;
      pair_r    <= pair_nxt;
      outcome_r <= outcome_nxt;
      dist_r    <= dist_nxt;
    end
  end

  assign dif.busy     = (state_r == phy_diag_pkg::DIAG_RUN);
  assign dif.outcome  = outcome_r;
  assign dif.distance = dist_r;
  assign testRun      = dif.busy;
  assign testPair     = pair_r;

  property p_result_capture;
    @(posedge core_clk) disable iff (srst)
      (dif.busy && testDone && !dif.stopReq)
        |=> (dif.outcome == $past(testOutcome)) && (dif.distance == $past(testDistance))
            && !dif.busy;
  endproperty
  a_result_capture: assert property (p_result_capture) else $error("result not captured");
endmodule

// ===== src/phy_cable_diag_link_intr_regs.sv
// Per-port register group: cable test control and result, link state,
// symbol error frame count, link event enables and sticky flags.
// Assumes a synchronous 16-bit register port with one-cycle strobes.
`timescale 1ns/100ps
module phy_cable_diag_link_intr_regs (
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  input  wire logic [11:0]                 regAddr,
  input  wire logic                        regWrEn,
  input  wire logic                        regRdEn,
  input  wire logic [15:0]                 regWrData,
  output logic      [15:0]                 regRdData,
  output logic                             regRdValid,
  input  wire logic                        gigLinkUp,
  input  wire logic                        fastLinkUp,
  input  wire logic                        jabberEvt,
  input  wire logic                        rxErrorEvt,
  input  wire logic                        pageRxEvt,
  input  wire logic                        parDetFaultEvt,
  input  wire logic                        partnerAckEvt,
  input  wire logic                        remoteFaultEvt,
  input  wire logic                        rxFrameEnd,
  input  wire logic                        rxFrameSymErr,
  output logic                             testRun,
  output phy_diag_pkg::diag_pair_t         testPair,
  input  wire logic                        testDone,
  input  wire phy_diag_pkg::diag_outcome_t testOutcome,
  input  wire logic [7:0]                  testDistance,
  output logic                             jabberCountEn,
  output logic                             portIrq
);
  diag_if                                dif ();
  flag_if #(.W(phy_diag_pkg::NUM_EVT))   fif ();

  cable_diag_seq u_seq (
    .core_clk     (core_clk),
    .srst         (srst),
    .dif          (dif.seq),
    .testRun      (testRun),
    .testPair     (testPair),
    .testDone     (testDone),
    .testOutcome  (testOutcome),
    .testDistance (testDistance)
  );

  event_flag_bank #(.W(phy_diag_pkg::NUM_EVT)) u_flags (
    .core_clk (core_clk),
    .srst     (srst),
    .fb       (fif.bank)
  );

  // Address decode
  logic hitDiag;
  logic hitLink;
  logic hitCnt;
  logic hitIrq;
  logic hitCtl;

  assign hitDiag = (regAddr == phy_diag_pkg::OFS_DIAG);
  assign hitLink = (regAddr == phy_diag_pkg::OFS_LINK);
  assign hitCnt  = (regAddr == phy_diag_pkg::OFS_SYMERR);
  assign hitIrq  = (regAddr == phy_diag_pkg::OFS_IRQ);
  assign hitCtl  = (regAddr == phy_diag_pkg::OFS_PHYCTL);

  logic diagWr;
  logic startBit;
  assign diagWr   = regWrEn && hitDiag;
  assign startBit = regWrData[phy_diag_pkg::DIAG_START_BIT];

  // A second start while running is ignored; abort only matters while busy
  assign dif.startReq = diagWr && startBit && !dif.busy;
  assign dif.stopReq  = diagWr && !startBit && dif.busy;
  assign dif.pairSel  = phy_diag_pkg::diag_pair_t'(regWrData[phy_diag_pkg::DIAG_PAIR_LSB +: 2]);

  // Writable control state
  phy_diag_pkg::diag_pair_t pair_r, pair_nxt;
  logic       rsvHi_r, rsvHi_nxt;
  logic [1:0] rsvLo_r, rsvLo_nxt;
  logic [7:0] irqEn_r, irqEn_nxt;
  logic       jabberEn_r, jabberEn_nxt;

  always_comb begin
    pair_nxt     = pair_r;
    rsvHi_nxt    = rsvHi_r;
    rsvLo_nxt    = rsvLo_r;
    irqEn_nxt    = irqEn_r;
    jabberEn_nxt = jabberEn_r;
    if (diagWr) begin
      pair_nxt  = dif.pairSel;
      rsvHi_nxt = regWrData[phy_diag_pkg::DIAG_RSV_HI];
      rsvLo_nxt = regWrData[phy_diag_pkg::DIAG_RSV_LSB +: 2];
    end
    if (regWrEn && hitIrq) begin
      irqEn_nxt = regWrData[phy_diag_pkg::IRQ_EN_LSB +: phy_diag_pkg::NUM_EVT];
    end
    if (regWrEn && hitCtl) begin
      jabberEn_nxt = regWrData[phy_diag_pkg::JABBER_EN_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pair_r     <= phy_diag_pkg::PAIR_A;
      rsvHi_r    <= phy_diag_pkg::DIAG_RSV_HI_RST;
      rsvLo_r    <= phy_diag_pkg::DIAG_RSV_LO_RST;
      irqEn_r    <= phy_diag_pkg::IRQ_EN_RST;
      jabberEn_r <= phy_diag_pkg::JABBER_EN_RST;
    end else begin
      pair_r     <= pair_nxt;
      rsvHi_r    <= rsvHi_nxt;
      rsvLo_r    <= rsvLo_nxt;
      irqEn_r    <= irqEn_nxt;
      jabberEn_r <= jabberEn_nxt;
    end
  end

  assign jabberCountEn = jabberEn_r;

  // Link transitions drive the link up and link down flags
  logic linkUp;
  logic linkPrev_r, linkPrev_nxt;
  logic linkRise;
  logic linkFall;

  assign linkUp   = gigLinkUp || fastLinkUp;
  assign linkRise = linkUp && !linkPrev_r;
  assign linkFall = !linkUp && linkPrev_r;

  always_comb begin
    linkPrev_nxt = linkUp;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      linkPrev_r <= 1'h0;
    end else begin
      linkPrev_r <= linkPrev_nxt;
    end
  end

  // Event collection into the sticky flags
  logic irqRead;
  assign irqRead = regRdEn && hitIrq;

  always_comb begin
    fif.setVec = '0;
    fif.setVec[phy_diag_pkg::EVT_JABBER]    = jabberEvt && jabberEn_r;
    fif.setVec[phy_diag_pkg::EVT_RX_ERR]    = rxErrorEvt;
    fif.setVec[phy_diag_pkg::EVT_PAGE_RX]   = pageRxEvt;
    fif.setVec[phy_diag_pkg::EVT_PAR_DET]   = parDetFaultEvt;
    fif.setVec[phy_diag_pkg::EVT_PART_ACK]  = partnerAckEvt;
    fif.setVec[phy_diag_pkg::EVT_LINK_DOWN] = linkFall;
    fif.setVec[phy_diag_pkg::EVT_REM_FAULT] = remoteFaultEvt;
    fif.setVec[phy_diag_pkg::EVT_LINK_UP]   = linkRise;
  end

  assign fif.clrAll = irqRead;

  // Level request from registered flags and enables
  assign portIrq = |(fif.flags & irqEn_r);

  // Symbol error frame counter, saturating so wrap never hides errors
  logic        cntInc;
  logic        cntRead;
  logic [15:0] cnt_r, cnt_nxt;

  assign cntInc  = rxFrameEnd && rxFrameSymErr;
  assign cntRead = regRdEn && hitCnt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (cntRead) begin
      cnt_nxt = cntInc ? 16'h0001 : phy_diag_pkg::CNT_RST;
    end else if (cntInc && (cnt_r != phy_diag_pkg::CNT_MAX)) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_r <= phy_diag_pkg::CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Read path, one cycle latency; unmapped offsets read zero
  logic [15:0] rdMux;
  logic [15:0] rdData_r, rdData_nxt;
  logic        rdValid_r, rdValid_nxt;

  always_comb begin
    rdMux = phy_diag_pkg::RD_ZERO;
    if (hitDiag) begin
      rdMux[phy_diag_pkg::DIAG_START_BIT]        = dif.busy;
      rdMux[phy_diag_pkg::DIAG_RSV_HI]           = rsvHi_r;
      rdMux[phy_diag_pkg::DIAG_PAIR_LSB +: 2]    = pair_r;
      rdMux[phy_diag_pkg::DIAG_RSV_LSB +: 2]     = rsvLo_r;
      rdMux[phy_diag_pkg::DIAG_STAT_LSB +: 2]    = dif.outcome;
      rdMux[phy_diag_pkg::DIAG_DIST_LSB +: 8]    = dif.distance;
    end else if (hitLink) begin
      rdMux[phy_diag_pkg::LINK_GIG_BIT]  = gigLinkUp;
      rdMux[phy_diag_pkg::LINK_FAST_BIT] = fastLinkUp;
    end else if (hitCnt) begin
      rdMux = cnt_r;
    end else if (hitIrq) begin
      rdMux = {irqEn_r, fif.flags};
    end else if (hitCtl) begin
      rdMux[phy_diag_pkg::JABBER_EN_BIT] = jabberEn_r;
    end
  end

  always_comb begin
    rdValid_nxt = regRdEn;
    rdData_nxt  = regRdEn ? rdMux : rdData_r;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdData_r  <= phy_diag_pkg::RD_ZERO;
      rdValid_r <= 1'h0;
    end else begin
      rdData_r  <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  assign regRdData  = rdData_r;
  assign regRdValid = rdValid_r;

  property p_start_runs;
    @(posedge core_clk) disable iff (srst)
      (diagWr && startBit && !dif.busy) |=> dif.busy && testRun;
  endproperty
  a_start_runs: assert property (p_start_runs) else $error("test did not start");

  property p_busy_read;
    @(posedge core_clk) disable iff (srst)
      (regRdEn && hitDiag) |=> regRdValid && (regRdData[15] == $past(dif.busy));
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("start bit read wrong");

  property p_abort;
    @(posedge core_clk) disable iff (srst)
      (diagWr && !startBit && dif.busy)
        |=> !dif.busy ##1 (dif.busy == $past(dif.startReq));
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_pair;
    @(posedge core_clk) disable iff (srst)
      dif.startReq |=> testPair == $past(regWrData[13:12]);
  endproperty
  a_pair: assert property (p_pair) else $error("pair not applied");

  property p_link_read;
    @(posedge core_clk) disable iff (srst)
      (regRdEn && hitLink)
        |=> regRdData == {14'h0000, $past(gigLinkUp), $past(fastLinkUp)};
  endproperty
  a_link_read: assert property (p_link_read) else $error("link status read wrong");

  property p_cnt_clear;
    @(posedge core_clk) disable iff (srst)
      (cntRead && !cntInc) |=> (cnt_r == 16'h0000) && (regRdData == $past(cnt_r));
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");

  property p_cnt_inc;
    @(posedge core_clk) disable iff (srst)
      (cntInc && !cntRead && (cnt_r != 16'hFFFF)) |=> cnt_r == $past(cnt_r) + 16'h0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("counter missed frame");

  property p_en_write;
    @(posedge core_clk) disable iff (srst)
      (regWrEn && hitIrq) |=> irqEn_r == $past(regWrData[15:8]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable byte lost");

  property p_flag_clear;
    @(posedge core_clk) disable iff (srst)
      (irqRead && (fif.setVec == 8'h00)) |=> fif.flags == 8'h00;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared");

  property p_link_up;
    @(posedge core_clk) disable iff (srst)
      $rose(linkUp) |-> ##1 fif.flags[0];
  endproperty
  a_link_up: assert property (p_link_up) else $error("link up not flagged");

  property p_jabber_gate;
    @(posedge core_clk) disable iff (srst)
      (!jabberEn_r && !fif.flags[7]) |=> !fif.flags[7];
  endproperty
  a_jabber_gate: assert property (p_jabber_gate) else $error("jabber flagged while off");

  property p_irq_drop;
    @(posedge core_clk) disable iff (srst)
      (irqRead && (fif.setVec == 8'h00) && !(regWrEn && hitIrq)) |=> !portIrq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq stuck after read");
endmodule

// ===== testbench/cable_tester_model.sv
// Behavioural cable tester on the far side of the test sequencer.
// Assumes testRun is a level from the device; answers after a set latency.
`timescale 1ns/100ps
module cable_tester_model (
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  input  wire logic                        testRun,
  input  wire phy_diag_pkg::diag_pair_t    testPair,
  input  wire logic [7:0]                  latency,
  input  wire phy_diag_pkg::diag_outcome_t resOutcome,
  input  wire logic [7:0]                  resDist,
  output logic                             testDone,
  output phy_diag_pkg::diag_outcome_t      testOutcome,
  output logic [7:0]                       testDistance
);
  int unsigned elapsed;

  // Results churn outside the done pulse, so late sampling reads garbage
  always @(posedge core_clk) begin
    testDone     <= 1'b0;
    testOutcome  <= phy_diag_pkg::diag_outcome_t'(~testOutcome);
    testDistance <= ~testDistance;
    if (srst) begin
      elapsed      <= 0;
      testOutcome  <= phy_diag_pkg::DIAG_NORMAL;
      testDistance <= 8'h00;
    end else if (!testRun) begin
      elapsed <= 0;
    end else begin
      elapsed <= elapsed + 1;
      if (elapsed == latency) begin
        testDone     <= 1'b1;
        testOutcome  <= resOutcome;
        testDistance <= resDist + 8'(testPair);
      end
    end
  end
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the per-port cable test, link and event registers.
// Assumes the cable tester model sits on the sequencer side of the block.
`timescale 1ns/100ps
module testbench;
  logic                        core_clk;
  logic                        srst;
  logic [11:0]                 regAddr;
  logic                        regWrEn;
  logic                        regRdEn;
  logic [15:0]                 regWrData;
  logic [15:0]                 regRdData;
  logic                        regRdValid;
  logic                        gigLinkUp;
  logic                        fastLinkUp;
  logic [7:0]                  evtVec;
  logic                        rxFrameEnd;
  logic                        rxFrameSymErr;
  logic                        testRun;
  phy_diag_pkg::diag_pair_t    testPair;
  logic                        testDone;
  phy_diag_pkg::diag_outcome_t testOutcome;
  logic [7:0]                  testDistance;
  logic                        jabberCountEn;
  logic                        portIrq;
  logic [7:0]                  tLat;
  phy_diag_pkg::diag_outcome_t tOut;
  logic [7:0]                  tDist;
  int                          nMismatch;
  int                          nTests;
  logic [7:0]                  mEn;
  logic [7:0]                  mFlags;
  logic [7:0]                  mDist;
  logic [15:0]                 mCnt;
  logic [1:0]                  mPair;
  logic [1:0]                  mRsv;
  logic [1:0]                  mOut;
  logic                        mRsvHi;
  logic                        mJab;
  logic                        mLink;
  int                          evs [6] = '{1, 3, 4, 5, 6, 7};

  phy_cable_diag_link_intr_regs phy_cable_diag_link_intr_regs_i (
    .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .gigLinkUp(gigLinkUp), .fastLinkUp(fastLinkUp),
    .jabberEvt(evtVec[7]), .rxErrorEvt(evtVec[6]), .pageRxEvt(evtVec[5]),
    .parDetFaultEvt(evtVec[4]), .partnerAckEvt(evtVec[3]),
    .remoteFaultEvt(evtVec[1]), .rxFrameEnd(rxFrameEnd), .rxFrameSymErr(rxFrameSymErr),
    .testRun(testRun), .testPair(testPair), .testDone(testDone),
    .testOutcome(testOutcome), .testDistance(testDistance),
    .jabberCountEn(jabberCountEn), .portIrq(portIrq));

  cable_tester_model cable_tester_model_i (
    .core_clk(core_clk), .srst(srst), .testRun(testRun), .testPair(testPair),
    .latency(tLat), .resOutcome(tOut), .resDist(tDist), .testDone(testDone),
    .testOutcome(testOutcome), .testDistance(testDistance));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      nMismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stopTest;
    $display("mismatches=%0d comparisons=%0d", nMismatch, nTests);
    if (nMismatch == 0 && nTests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] exp, input logic [15:0] msk);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    chk({15'h0000, regRdValid}, 16'h0001);
    chk(regRdData & msk, exp & msk);
  endtask

  // Let flag updates settle before comparing the request line
  task automatic irqChk;
    repeat (2) @(posedge core_clk);
    #1;
    chk({15'h0000, portIrq}, {15'h0000, |(mFlags & mEn)});
  endtask

  task automatic evt(input int i);
    @(posedge core_clk);
    evtVec[i] <= 1'b1;
    @(posedge core_clk);
    evtVec <= 8'h00;
    if (i != 7 || mJab) mFlags[i] = 1'b1;
  endtask

  task automatic setLink(input logic g, input logic f);
    @(posedge core_clk);
    gigLinkUp  <= g;
    fastLinkUp <= f;
    @(posedge core_clk);
    if (!mLink && (g | f)) mFlags[0] = 1'b1;
    if (mLink && !(g | f)) mFlags[2] = 1'b1;
    mLink = g | f;
  endtask

  task automatic frame(input logic e, input logic fin);
    @(posedge core_clk);
    rxFrameEnd    <= fin;
    rxFrameSymErr <= e;
    @(posedge core_clk);
    rxFrameEnd    <= 1'b0;
    rxFrameSymErr <= 1'b0;
    if (fin && e) mCnt++;
  endtask

  function automatic logic [15:0] diagExp(input logic busy);
    return {busy, mRsvHi, mPair, mRsv, mOut, mDist};
  endfunction

  // Distance is only meaningful for open and short outcomes
  function automatic logic [15:0] diagMsk;
    return (mOut == 2'h1 || mOut == 2'h2) ? 16'hFFFF : 16'hFF00;
  endfunction

  task automatic diagRun(input logic [1:0] p, input logic [1:0] o);
    logic [2:0] rsv;
    int         i;
    rsv = 3'($urandom);
    tLat  <= 8'(10 + $urandom_range(0, 20));
    tOut  <= phy_diag_pkg::diag_outcome_t'(o);
    tDist <= 8'($urandom);
    wr(phy_diag_pkg::OFS_DIAG, {1'b1, rsv[2], p, rsv[1:0], 10'h000});
    mRsvHi = rsv[2];
    mPair  = p;
    mRsv   = rsv[1:0];
    #1;
    chk({14'h0000, testPair}, {14'h0000, p});
    chk({15'h0000, testRun}, 16'h0001);
    rd(phy_diag_pkg::OFS_DIAG, diagExp(1'b1), diagMsk());
    for (i = 0; i < 300 && testRun !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk({15'h0000, testRun}, 16'h0000);
    mOut  = o;
    mDist = tDist + 8'(p);
    rd(phy_diag_pkg::OFS_DIAG, diagExp(1'b0), diagMsk());
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    nMismatch++;
    stopTest();
  end

  initial begin
    srst = 1'b1; regAddr = 12'h000; regWrEn = 1'b0; regRdEn = 1'b0;
    regWrData = 16'h0000; gigLinkUp = 1'b0; fastLinkUp = 1'b0; evtVec = 8'h00;
    rxFrameEnd = 1'b0; rxFrameSymErr = 1'b0; tLat = 8'h10;
    tOut = phy_diag_pkg::DIAG_NORMAL; tDist = 8'h00; nMismatch = 0; nTests = 0;
    mEn = 8'h00; mFlags = 8'h00; mDist = 8'h00; mCnt = 16'h0000; mPair = 2'h0;
    mRsv = 2'h0; mOut = 2'h0; mRsvHi = 1'b0; mJab = 1'b1; mLink = 1'b0;
    void'($urandom(32'h66c1_1cf6));
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk({15'h0000, jabberCountEn}, 16'h0001);
    chk({15'h0000, portIrq}, 16'h0000);
    rd(phy_diag_pkg::OFS_DIAG, 16'h0000, 16'hFFFF);
    rd(phy_diag_pkg::OFS_IRQ, 16'h0000, 16'hFFFF);
    rd(phy_diag_pkg::OFS_PHYCTL, 16'h0200, 16'hFFFF);
    rd(12'h128, 16'h0000, 16'hFFFF);
    for (int k = 0; k < 4; k++) diagRun(2'(k), 2'(3 - k));
    diagRun(2'(k_fix()), 2'h1);
    tLat <= 8'd200;
    wr(phy_diag_pkg::OFS_DIAG, 16'h8000);
    mPair = 2'h0; mRsv = 2'h0; mRsvHi = 1'b0;
    wr(phy_diag_pkg::OFS_DIAG, 16'h0000);
    #1;
    chk({15'h0000, testRun}, 16'h0000);
    rd(phy_diag_pkg::OFS_DIAG, diagExp(1'b0), diagMsk());
    mEn = 8'hFF;
    wr(phy_diag_pkg::OFS_IRQ, 16'hFF00);
    wr(phy_diag_pkg::OFS_LINK, 16'hFFFF);
    for (int k = 0; k < 4; k++) begin
      setLink(k[1], k[0]);
      rd(phy_diag_pkg::OFS_LINK, {14'h0000, 2'(k)}, 16'hFFFF);
    end
    setLink(1'b0, 1'b0);
    irqChk();
    rd(phy_diag_pkg::OFS_IRQ, {mEn, mFlags}, 16'hFFFF);
    mFlags = 8'h00;
    irqChk();
    foreach (evs[k]) begin
      mEn = 8'($urandom);
      wr(phy_diag_pkg::OFS_IRQ, {mEn, 8'h00});
      evt(evs[k]);
      irqChk();
      rd(phy_diag_pkg::OFS_IRQ, {mEn, mFlags}, 16'hFFFF);
      mFlags = 8'h00;
      irqChk();
    end
    wr(phy_diag_pkg::OFS_PHYCTL, 16'h0000);
    mJab = 1'b0;
    #1;
    chk({15'h0000, jabberCountEn}, 16'h0000);
    evt(7);
    rd(phy_diag_pkg::OFS_IRQ, {mEn, mFlags}, 16'hFFFF);
    wr(phy_diag_pkg::OFS_PHYCTL, 16'h0200);
    mJab = 1'b1;
    rd(phy_diag_pkg::OFS_PHYCTL, 16'h0200, 16'hFFFF);
    wr(phy_diag_pkg::OFS_SYMERR, 16'hFFFF);
    repeat ($urandom_range(5, 30)) frame(1'($urandom), 1'($urandom));
    rd(phy_diag_pkg::OFS_SYMERR, mCnt, 16'hFFFF);
    mCnt = 16'h0000;
    rd(phy_diag_pkg::OFS_SYMERR, 16'h0000, 16'hFFFF);
    stopTest();
  end

  function automatic int k_fix;
    return $urandom_range(0, 3);
  endfunction
endmodule
